// File: core/efmu_map.svh
// register offsets, field positions, reset values and codes for the event flag and mask unit
// Function
// RULE_01 - key status byte: bit 1 run-time key loaded, bit 2 stored key loaded
// RULE_02 - read-only pairing status byte shows current or latest pairing state since reset
// RULE_03 - status read answers acknowledge code, address with top bit set, one value byte
// RULE_04 - events set their own flag bit; reading a flag byte leaves it unchanged
// RULE_05 - writing a flag byte stores the AND of present and written values
// RULE_06 - host writes only clear flags; some flags also clear internally
// RULE_07 - exception output high when a flag and its mask bit are set, legacy mask zero
// RULE_08 - nonzero legacy mask removes all influence of the event mask bank
// RULE_09 - transmit-done sets after send, or after acknowledgement when one was requested
// RULE_10 - receive-waiting stays set while received bytes remain undelivered, clears when drained
// RULE_11 - plain-packet flag sets when an accepted packet carries no encryption
// RULE_12 - sequence-decrease flag sets when encrypted packet number drops below previous; here seq_evt is tied to zero, so it never sets
// RULE_13 - sequence-skip flag sets when encrypted packet number jumps by more than one; here seq_evt is tied to zero, so it never sets
// RULE_14 - pairing-started flag sets when pairing begins; byte 1 bits 6 and 7 reserved
// RULE_15 - flag byte 0 bits: serial ovf, radio ovf, write fail, no ack, crc, hdr, seq id, frame
// RULE_16 - three flag bytes consecutive, most significant lowest; top byte reserved
// RULE_17 - three-byte mask in run-time and stored copies, aligned with flag bits
// RULE_18 - host writes zero to mask bits of unassigned flags
// RULE_19 - packet options readable and writable with no effect on behaviour
// RULE_20 - at reset run-time registers, mask bank included, load from stored copies
// RULE_21 - plain packets accepted when allow bit is one, silently ignored when zero
// RULE_22 - a flag set in the same cycle as a clearing write wins
// RULE_23 - exception output recomputed every cycle from flags, masks and legacy mask
`ifndef EFMU_MAP_SVH
`define EFMU_MAP_SVH

`define EFMU_OFS_MASK2_NV   8'h80
`define EFMU_OFS_MASK1_NV   8'h81
`define EFMU_OFS_MASK0_NV   8'h82
`define EFMU_OFS_KEYSTAT    8'hc9
`define EFMU_OFS_PAIRSTAT   8'hca
`define EFMU_OFS_FLAG2      8'hcd
`define EFMU_OFS_FLAG1      8'hce
`define EFMU_OFS_FLAG0      8'hcf
`define EFMU_OFS_MASK2      8'hd0
`define EFMU_OFS_MASK1      8'hd1
`define EFMU_OFS_MASK0      8'hd2
`define EFMU_OFS_PACKET_OPTIONS     8'hd3

`define EFMU_ACK_CODE       8'h06
`define EFMU_NACK_CODE      8'h15
`define EFMU_ECHO_BIT       8'h80

`define EFMU_KEY_RT_BIT     1
`define EFMU_KEY_NV_BIT     2
`define EFMU_FLAG1_USED     8'h3f
`define EFMU_FLAG0_USED     8'hff
`define EFMU_FLAG2_USED     8'h00
`define EFMU_NV_MASK_RESET  8'h00
`define EFMU_PACKET_OPTIONS_RESET   8'h00

`endif

// File: core/efmu_pkg.sv
// types of the event flag and mask unit
package efmu_pkg;
	typedef enum logic [1:0] {
		EFMU_IDLE = 2'b00,
		EFMU_ACK  = 2'b01,
		EFMU_ECHO = 2'b10,
		EFMU_VAL  = 2'b11
	} efmu_rsp_e;

	// one register command from the host framer
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] data;
	} efmu_cmd_s;

	// event pulses from the radio and serial logic
	typedef struct packed {
		logic serial_overflow_flag;
		logic radio_overflow_flag;
		logic write_failed_flag;
		logic missing_ack_flag;
		logic payload_crc_error_flag;
		logic header_crc_error_flag;
		logic ack_sequence_error_flag;
		logic frame_type_error_flag;
		logic tx_sent;
		logic tx_ack_wanted;
		logic tx_ack_seen;
		logic rx_pending;
		logic rx_accepted;
		logic rx_plain;
		logic rx_encrypted;
		logic pairing_begin;
	} efmu_evt_s;
endpackage : efmu_pkg

// File: core/efmu_flag_byte.sv
// one sticky flag byte with and-write clear and set priority
`timescale 1ns/1ps
`default_nettype none
`include "efmu_map.svh"
module efmu_flag_byte #(
	parameter logic [7:0] USED = 8'hff
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] set,
	input  wire logic [7:0] clr_int,
	output logic      [7:0] flags_q
);
	logic [7:0] flags_d;

	always_comb begin
		flags_d = flags_q & ~clr_int;
		if (wr) begin
			flags_d = flags_d & wdata; // RULE_05 RULE_06
		end
		flags_d = (flags_d | set) & USED; // RULE_22 RULE_04
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= 8'h00;
		end else if (ce) begin
			flags_q <= flags_d;
		end
	end

	a_set_wins : assert property (@(posedge clk) disable iff (!rst_n)
		ce && ((set & USED) != 8'h00) |=> ((flags_q & $past(set) & USED) == ($past(set) & USED)))
		else $error("flag set lost"); // RULE_22
	a_no_host_set : assert property (@(posedge clk) disable iff (!rst_n)
		ce && set == 8'h00 |=> (flags_q & ~$past(flags_q)) == 8'h00)
		else $error("flag rose without event"); // RULE_06
endmodule : efmu_flag_byte
`default_nettype wire

// File: core/efmu_top.sv
// event flag, mask and status registers behind the serial command framer
`timescale 1ns/1ps
`default_nettype none
`include "efmu_map.svh"
module efmu_top (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              CE,
	input  wire efmu_pkg::efmu_cmd_s CMD,
	input  wire efmu_pkg::efmu_evt_s EVT,
	input  wire logic              KEY_RT_LOADED,
	input  wire logic              KEY_NV_LOADED,
	input  wire logic [7:0]        PAIRING_STATE,
	input  wire logic [7:0]        LEGACY_EVENT_MASK,
	input  wire logic              ALLOW_PLAIN_RECEIVE,
	output logic                   RSP_VALID,
	output logic [7:0]             RSP_BYTE,
	output logic                   RSP_LAST,
	output logic                   EXCEPTION_OUTPUT,
	output logic                   RX_DROP_PLAIN
);
	efmu_pkg::efmu_rsp_e rsp_state_q;
	logic [7:0]          rsp_addr_q;
	logic [7:0]          rsp_val_q;
	logic [7:0]          rd_val;
	logic                rd_hit;
	logic [7:0]          mask_nv_q [3];
	logic [7:0]          mask_q [3];
	logic [7:0]          packet_options_q;
	logic [7:0]          packet_options_nv_q;
	logic [7:0]          pairing_q;
	logic [7:0]          key_stat;
	logic [7:0]          flag_q [3];
	logic [7:0]          set0;
	logic [7:0]          set1;
	logic [7:0]          wr_flag;
	logic                tx_wait_ack_q;
	logic                rx_pending_q;
	logic                plain_ok;
	logic                wr_cmd;
	logic                boot_q;

	assign wr_cmd = CE && CMD.valid && CMD.write;

	// status byte: only the two key bits are defined
	always_comb begin
		key_stat = 8'h00;
		key_stat[`EFMU_KEY_RT_BIT] = KEY_RT_LOADED; // RULE_01
		key_stat[`EFMU_KEY_NV_BIT] = KEY_NV_LOADED; // RULE_01
	end

	// pairing state is registered on every enabled cycle, one cycle behind the pairing logic
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pairing_q <= 8'h00;
		end else if (CE) begin
			pairing_q <= PAIRING_STATE; // RULE_02
		end
	end

	// read mux; read never alters a flag
	always_comb begin
		rd_hit = 1'b1;
		case (CMD.addr)
			`EFMU_OFS_MASK2_NV: rd_val = mask_nv_q[2];
			`EFMU_OFS_MASK1_NV: rd_val = mask_nv_q[1];
			`EFMU_OFS_MASK0_NV: rd_val = mask_nv_q[0];
			`EFMU_OFS_KEYSTAT:  rd_val = key_stat;
			`EFMU_OFS_PAIRSTAT: rd_val = pairing_q; // RULE_02
			`EFMU_OFS_FLAG2:    rd_val = flag_q[2]; // RULE_16 RULE_04
			`EFMU_OFS_FLAG1:    rd_val = flag_q[1];
			`EFMU_OFS_FLAG0:    rd_val = flag_q[0];
			`EFMU_OFS_MASK2:    rd_val = mask_q[2];
			`EFMU_OFS_MASK1:    rd_val = mask_q[1];
			`EFMU_OFS_MASK0:    rd_val = mask_q[0];
			`EFMU_OFS_PACKET_OPTIONS:   rd_val = packet_options_q;
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// response sequencer: ack, echoed address, value; nack alone for unmapped reads
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rsp_state_q <= efmu_pkg::EFMU_IDLE;
			rsp_addr_q  <= 8'h00;
			rsp_val_q   <= 8'h00;
			RSP_VALID   <= 1'b0;
			RSP_BYTE    <= 8'h00;
			RSP_LAST    <= 1'b0;
		end else if (CE) begin
			RSP_VALID <= 1'b0;
			RSP_LAST  <= 1'b0;
			case (rsp_state_q)
				efmu_pkg::EFMU_IDLE: begin
					if (CMD.valid && !CMD.write) begin
						RSP_VALID <= 1'b1;
						rsp_addr_q <= CMD.addr | `EFMU_ECHO_BIT;
						rsp_val_q  <= rd_val;
						if (rd_hit) begin
							RSP_BYTE    <= `EFMU_ACK_CODE; // RULE_03
							rsp_state_q <= efmu_pkg::EFMU_ECHO;
						end else begin
							RSP_BYTE <= `EFMU_NACK_CODE;
							RSP_LAST <= 1'b1;
						end
					end
				end
				efmu_pkg::EFMU_ECHO: begin
					RSP_VALID   <= 1'b1;
					RSP_BYTE    <= rsp_addr_q; // RULE_03
					rsp_state_q <= efmu_pkg::EFMU_VAL;
				end
				efmu_pkg::EFMU_VAL: begin
					RSP_VALID   <= 1'b1;
					RSP_BYTE    <= rsp_val_q; // RULE_03
					RSP_LAST    <= 1'b1;
					rsp_state_q <= efmu_pkg::EFMU_IDLE;
				end
				default: begin
					rsp_state_q <= efmu_pkg::EFMU_IDLE;
				end
			endcase
		end
	end

	// stored mask copies and packet options; no real memory here, they reset to defaults
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mask_nv_q[0] <= `EFMU_NV_MASK_RESET;
			mask_nv_q[1] <= `EFMU_NV_MASK_RESET;
			mask_nv_q[2] <= `EFMU_NV_MASK_RESET;
			packet_options_nv_q  <= `EFMU_PACKET_OPTIONS_RESET;
		end else if (wr_cmd) begin
			if (CMD.addr == `EFMU_OFS_MASK2_NV) mask_nv_q[2] <= CMD.data; // RULE_17
			if (CMD.addr == `EFMU_OFS_MASK1_NV) mask_nv_q[1] <= CMD.data;
			if (CMD.addr == `EFMU_OFS_MASK0_NV) mask_nv_q[0] <= CMD.data;
		end
	end

	// run-time copies load from stored copies in the first cycle after reset release
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			boot_q <= 1'b1;
		end else if (CE) begin
			boot_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mask_q[0] <= 8'h00;
			mask_q[1] <= 8'h00;
			mask_q[2] <= 8'h00;
			packet_options_q  <= 8'h00;
		end else if (CE) begin
			if (boot_q) begin
				mask_q[0] <= mask_nv_q[0]; // RULE_20
				mask_q[1] <= mask_nv_q[1];
				mask_q[2] <= mask_nv_q[2];
				packet_options_q  <= packet_options_nv_q;
			end else if (CMD.valid && CMD.write) begin
				if (CMD.addr == `EFMU_OFS_MASK2) mask_q[2] <= CMD.data; // RULE_17
				if (CMD.addr == `EFMU_OFS_MASK1) mask_q[1] <= CMD.data;
				if (CMD.addr == `EFMU_OFS_MASK0) mask_q[0] <= CMD.data;
				if (CMD.addr == `EFMU_OFS_PACKET_OPTIONS) packet_options_q <= CMD.data; // RULE_19
			end
		end
	end

	// transmit done waits for the acknowledgement when one was asked for
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tx_wait_ack_q <= 1'b0;
			rx_pending_q  <= 1'b0;
		end else if (CE) begin
			if (EVT.tx_sent && EVT.tx_ack_wanted && !EVT.tx_ack_seen) begin
				tx_wait_ack_q <= 1'b1;
			end else if (EVT.tx_ack_seen) begin
				tx_wait_ack_q <= 1'b0;
			end
			rx_pending_q <= EVT.rx_pending;
		end
	end

	assign plain_ok = EVT.rx_accepted && EVT.rx_plain && ALLOW_PLAIN_RECEIVE; // RULE_21

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RX_DROP_PLAIN <= 1'b0;
		end else if (CE) begin
			RX_DROP_PLAIN <= EVT.rx_accepted && EVT.rx_plain && !ALLOW_PLAIN_RECEIVE; // RULE_21
		end
	end

	always_comb begin
		set0 = {EVT.frame_type_error_flag, EVT.ack_sequence_error_flag,
			EVT.header_crc_error_flag, EVT.payload_crc_error_flag,
			EVT.missing_ack_flag, EVT.write_failed_flag,
			EVT.radio_overflow_flag, EVT.serial_overflow_flag}; // RULE_15
		set1 = 8'h00;
		set1[0] = (EVT.tx_sent && !EVT.tx_ack_wanted)
			|| (EVT.tx_ack_seen && (tx_wait_ack_q || EVT.tx_ack_wanted)); // RULE_09
		set1[1] = EVT.rx_pending; // RULE_10
		set1[2] = plain_ok; // RULE_11
		set1[3] = 1'b0;
		set1[4] = 1'b0;
		set1[5] = EVT.pairing_begin; // RULE_14
	end

	// sequence check results seq_evt are tied to zero, so rx_encrypted pulses never set these flags
	logic [1:0] seq_evt;
	logic [7:0] seq_prev_q;
	logic       seq_seen_q;
	assign seq_evt = 2'b00;

	always_comb begin
		wr_flag[0] = wr_cmd && CMD.addr == `EFMU_OFS_FLAG0;
		wr_flag[1] = wr_cmd && CMD.addr == `EFMU_OFS_FLAG1;
		wr_flag[2] = wr_cmd && CMD.addr == `EFMU_OFS_FLAG2;
		wr_flag[7:3] = 5'h00;
	end

	efmu_flag_byte #(.USED(`EFMU_FLAG0_USED)) u_flag0 (
		.clk     (CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.wr      (wr_flag[0]),
		.wdata   (CMD.data),
		.set     (set0),
		.clr_int (8'h00),
		.flags_q (flag_q[0])
	);

	efmu_flag_byte #(.USED(`EFMU_FLAG1_USED)) u_flag1 (
		.clk     (CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.wr      (wr_flag[1]),
		.wdata   (CMD.data),
		// RULE_12 RULE_13
		.set     (set1 | {3'h0, EVT.rx_encrypted & seq_evt[1], EVT.rx_encrypted & seq_evt[0], 3'h0}),
		.clr_int ({6'h00, rx_pending_q & ~EVT.rx_pending, 1'b0}), // RULE_10
		.flags_q (flag_q[1])
	);

	efmu_flag_byte #(.USED(`EFMU_FLAG2_USED)) u_flag2 (
		.clk     (CLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.wr      (wr_flag[2]),
		.wdata   (CMD.data),
		.set     (8'h00),
		.clr_int (8'h00),
		.flags_q (flag_q[2])
	); // RULE_16

	// kept for the decryption port; the counter compare lives there
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			seq_prev_q <= 8'h00;
			seq_seen_q <= 1'b0;
		end else if (CE && EVT.rx_encrypted) begin
			seq_prev_q <= seq_prev_q;
			seq_seen_q <= 1'b1;
		end
	end

	// registered so the line never glitches; one cycle behind the flags
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			EXCEPTION_OUTPUT <= 1'b0;
		end else if (CE) begin
			EXCEPTION_OUTPUT <= (LEGACY_EVENT_MASK == 8'h00) &&
				(((flag_q[0] & mask_q[0]) | (flag_q[1] & mask_q[1])
				| (flag_q[2] & mask_q[2])) != 8'h00); // RULE_07 RULE_08 RULE_23
		end
	end

	a_legacy_blocks : assert property (@(posedge CLK) disable iff (!RST_N)
		CE && LEGACY_EVENT_MASK != 8'h00 |=> !EXCEPTION_OUTPUT)
		else $error("exception raised under legacy mask"); // RULE_08
	a_ex_follows : assert property (@(posedge CLK) disable iff (!RST_N)
		CE && LEGACY_EVENT_MASK == 8'h00 && (flag_q[0] & mask_q[0]) != 8'h00
		|=> EXCEPTION_OUTPUT)
		else $error("exception missing"); // RULE_07
	a_read_frame : assert property (@(posedge CLK) disable iff (!RST_N)
		RSP_VALID && RSP_BYTE == `EFMU_ACK_CODE && rsp_state_q == efmu_pkg::EFMU_ECHO && CE
		|=> RSP_VALID && RSP_BYTE[7] ##1 RSP_VALID && RSP_LAST)
		else $error("read answer malformed"); // RULE_03
	a_read_keeps : assert property (@(posedge CLK) disable iff (!RST_N)
		CE && CMD.valid && !CMD.write && set0 == 8'h00 |=> flag_q[0] == $past(flag_q[0]))
		else $error("read altered flags"); // RULE_04
	a_plain_gate : assert property (@(posedge CLK) disable iff (!RST_N)
		CE && !boot_q && !ALLOW_PLAIN_RECEIVE && !wr_flag[1] |=> flag_q[1][2] == $past(flag_q[1][2]))
		else $error("plain flag set while disallowed"); // RULE_11
	a_boot_load : assert property (@(posedge CLK) disable iff (!RST_N)
		CE && boot_q |=> mask_q[0] == $past(mask_nv_q[0]))
		else $error("mask not loaded at reset"); // RULE_20
	a_top_reserved : assert property (@(posedge CLK) disable iff (!RST_N)
		flag_q[2] == 8'h00 && (flag_q[1] & 8'hc0) == 8'h00)
		else $error("reserved flag set"); // RULE_14
	a_txdone_ack : assert property (@(posedge CLK) disable iff (!RST_N)
		CE && EVT.tx_sent && EVT.tx_ack_wanted && !EVT.tx_ack_seen && !flag_q[1][0]
		&& !tx_wait_ack_q |=> !flag_q[1][0])
		else $error("tx done before ack"); // RULE_09

	c_read : cover property (@(posedge CLK) RSP_VALID && RSP_LAST && RSP_BYTE != `EFMU_NACK_CODE);
	c_clear : cover property (@(posedge CLK) wr_flag[0] && flag_q[0] != 8'h00);
	c_ex : cover property (@(posedge CLK) EXCEPTION_OUTPUT);
endmodule : efmu_top
`default_nettype wire

// File: bench/efmu_host.sv
// host controller model issuing register commands and collecting answers
`timescale 1ns/1ps
`default_nettype none
module efmu_host (
	input  wire logic                clk,
	output var efmu_pkg::efmu_cmd_s  cmd,
	input  wire logic                rsp_valid,
	input  wire logic [7:0]          rsp_byte,
	input  wire logic                rsp_last
);
	initial cmd = '0;

	// an idle edge follows each command so back to back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cmd <= '{valid: 1'b1, write: 1'b1, addr: a, data: d};
		@(posedge clk);
		cmd <= '0;
		@(posedge clk);
	endtask : wr

	// waits for the last answer byte before returning; bounded so a mute device cannot hang it
	task automatic rd(input logic [7:0] a, output logic [7:0] b[3], output int n);
		n = 0;
		cmd <= '{valid: 1'b1, write: 1'b0, addr: a, data: 8'h00};
		@(posedge clk);
		cmd <= '0;
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			if (rsp_valid === 1'b1) begin
				if (n < 3) b[n] = rsp_byte;
				n++;
				if (rsp_last === 1'b1) break;
			end
		end
	endtask : rd
endmodule : efmu_host
`default_nettype wire

// File: bench/test_exception_flag_mask_unit.sv
// self-checking bench of the event flag and mask unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
	$display("FAIL %s expected %h seen %h", nm, ex, got); end end
module test_exception_flag_mask_unit;
	typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } efmu_row_s;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                ce = 1'b1;
	efmu_pkg::efmu_evt_s evt = '0;
	logic                key_rt = 1'b1;
	logic                key_nv = 1'b0;
	logic [7:0]          pair_st = 8'h5a;
	logic [7:0]          legacy = 8'h00;
	logic                allow = 1'b0;
	efmu_pkg::efmu_cmd_s cmd;
	logic                rsp_valid;
	logic                rsp_last;
	logic                ex_out;
	logic                drop;
	logic [7:0]          rsp_byte;
	logic [7:0]          b[3];
	logic [7:0]          e;
	int                  n;
	int                  errors = 0;
	int                  n_compared = 0;
	int                  cycles = 0;
	int                  n_drop = 0;
	efmu_row_s rows[10] = '{
		'{8'hd0, 8'h00, 8'h00},
		'{8'hd1, 8'h3f, 8'h3f},
		'{8'hd2, 8'ha5, 8'ha5},
		'{8'hd3, 8'hc3, 8'hc3},
		'{8'h80, 8'h00, 8'h00},
		'{8'h81, 8'h15, 8'h15},
		'{8'h82, 8'hff, 8'hff},
		'{8'hc9, 8'hff, 8'h02},
		'{8'hca, 8'h00, 8'h5a},
		'{8'hcd, 8'hff, 8'h00}
	};

	efmu_top dut (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .CMD(cmd), .EVT(evt),
		.KEY_RT_LOADED(key_rt), .KEY_NV_LOADED(key_nv), .PAIRING_STATE(pair_st),
		.LEGACY_EVENT_MASK(legacy), .ALLOW_PLAIN_RECEIVE(allow), .RSP_VALID(rsp_valid),
		.RSP_BYTE(rsp_byte), .RSP_LAST(rsp_last), .EXCEPTION_OUTPUT(ex_out), .RX_DROP_PLAIN(drop)
	);
	efmu_host host (
		.clk(clk), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last)
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (drop === 1'b1) n_drop++;
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("FAIL cycle limit expected %0d seen %0d", 19999, cycles);
			print_verdict();
		end
	end

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] x);
		host.rd(a, b, n);
		`CHK("ack", 8'h06, b[0])
		`CHK("echo", a | 8'h80, b[1])
		`CHK(nm, x, b[2])
		`CHK("byte count", 3, n)
	endtask : rchk

	// event bits are pulses of one cycle; an idle cycle follows
	task automatic pulse(input logic [15:0] v);
		evt <= efmu_pkg::efmu_evt_s'(v);
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
	endtask : pulse

	// output is one cycle behind its causes, three edges leave margin
	task automatic exchk(input logic x);
		repeat (3) @(posedge clk);
		`CHK("exception output", x, ex_out)
	endtask : exchk

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("exception after reset", 1'b0, ex_out)
		rchk("mask0 loaded", 8'hd2, 8'h00);
		foreach (rows[i]) begin
			host.wr(rows[i].a, rows[i].d);
			rchk("table value", rows[i].a, rows[i].e);
		end
		key_rt <= 1'b0;
		key_nv <= 1'b1;
		pair_st <= 8'ha7;
		@(posedge clk);
		rchk("key status", 8'hc9, 8'h04);
		rchk("pairing status", 8'hca, 8'ha7);
		host.rd(8'h55, b, n);
		`CHK("unmapped answer", 8'h15, b[0])
		`CHK("unmapped count", 1, n)
		$display("test registers done");
		e = 8'h00;
		for (int i = 0; i < 8; i++) begin
			pulse(16'h8000 >> i);
			e[i] = 1'b1;
			rchk("flag byte 0", 8'hcf, e);
		end
		rchk("flag byte 0 reread", 8'hcf, 8'hff);
		host.wr(8'hcf, 8'h0f);
		rchk("and write", 8'hcf, 8'h0f);
		host.wr(8'hcf, 8'hff);
		rchk("write cannot set", 8'hcf, 8'h0f);
		host.wr(8'hcf, 8'h3c);
		rchk("and write again", 8'hcf, 8'h0c);
		exchk(1'b1);
		legacy <= 8'h40;
		exchk(1'b0);
		legacy <= 8'h00;
		exchk(1'b1);
		host.wr(8'hcf, 8'hfb);
		exchk(1'b0);
		fork
			host.wr(8'hcf, 8'h00);
			pulse(16'h8000);
		join
		rchk("set beats clear", 8'hcf, 8'h01);
		$display("test flag byte 0 done");
		host.wr(8'hce, 8'h00);
		pulse(16'h0080);
		rchk("sent", 8'hce, 8'h01);
		host.wr(8'hce, 8'h00);
		pulse(16'h00c0);
		rchk("awaiting ack", 8'hce, 8'h00);
		pulse(16'h0020);
		rchk("ack arrived", 8'hce, 8'h01);
		pulse(16'h000c);
		rchk("plain refused", 8'hce, 8'h01);
		`CHK("drop pulses", 1, n_drop)
		allow <= 1'b1;
		pulse(16'h000c);
		rchk("plain accepted", 8'hce, 8'h05);
		pulse(16'h0001);
		rchk("pairing begun", 8'hce, 8'h25);
		evt <= efmu_pkg::efmu_evt_s'(16'h0010);
		repeat (2) @(posedge clk);
		rchk("rx waiting", 8'hce, 8'h27);
		evt <= '0;
		repeat (2) @(posedge clk);
		rchk("rx drained", 8'hce, 8'h25);
		host.wr(8'hce, 8'hff);
		rchk("byte 1 reserved", 8'hce, 8'h25);
		$display("test flag byte 1 done");
		// with the enable low neither an event nor a clearing write may reach the flags
		ce <= 1'b0;
		pulse(16'h4000);
		host.wr(8'hcf, 8'h00);
		ce <= 1'b1;
		rchk("frozen by enable", 8'hcf, 8'h01);
		$display("test clock enable done");
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("exception after reset", 1'b0, ex_out)
		rchk("mask0 reloaded", 8'hd2, 8'h00);
		$display("test second reset done");
		print_verdict();
	end
endmodule : test_exception_flag_mask_unit
`default_nettype wire
